// >>> common/bcf_cfg.svh
// constants for the buck constant-on-time and fault sequencing block
`ifndef BCF_CFG_SVH
`define BCF_CFG_SVH
// clock and time figures
`define BCF_CLK_PERIOD_NS 5
`define BCF_MIN_OFF_NS    300
`define BCF_MIN_OFF_CYC   ((`BCF_MIN_OFF_NS + `BCF_CLK_PERIOD_NS - 1) / `BCF_CLK_PERIOD_NS)
`define BCF_UV_DELAY_US   32
`define BCF_UV_DELAY_CYC  ((`BCF_UV_DELAY_US * 1000) / `BCF_CLK_PERIOD_NS)
`define BCF_OC_LIMIT      16
`define BCF_RECOVER_CYC   1024
`define BCF_SLEW_DIV      8
// on-time charge: on cycles = charge / input level
`define BCF_ON_CHARGE     16'h0c00
// target units: 1 lsb = 9.375 mV / 16
`define BCF_VT_BASE       12'h400
`define BCF_VT_SHIFT      4
// over and under voltage ratios (6/5 = +20 %, 7/10 = 70 %)
`define BCF_OV_SENSE_MUL  16'h0005
`define BCF_OV_REF_MUL    16'h0006
`define BCF_UV_SENSE_MUL  16'h000a
`define BCF_UV_REF_MUL    16'h0007
// configuration fields and defaults
`define BCF_CFG_PROT_LATCH 0
`define BCF_CFG_SUSPEND    1
`define BCF_CFG_LIGHT      2
`define BCF_CFG_DEFAULT    3'h5
`define BCF_CODE_DEFAULT   7'h00
`endif

// >>> common/bcf_pkg.sv
// types shared by the buck control block
`default_nettype none
package bcf_pkg;
  // switching sequencer states, one-hot
  typedef enum logic [4:0] {
    st_off    = 5'h01,
    st_idle   = 5'h02,
    st_on     = 5'h04,
    st_minoff = 5'h08,
    st_latch  = 5'h10
  } bcf_state_t;
endpackage
`default_nettype wire

// >>> rtl/bcf_oneshot.sv
// input feed-forward on-time one-shot
`timescale 1ns/10ps
`default_nettype none
`include "bcf_cfg.svh"
module bcf_oneshot #(
  parameter int VW = 8,
  parameter logic [15:0] CHARGE = `BCF_ON_CHARGE
) (
  input  wire logic          clock_i,
  input  wire logic          rst_n_i,
  input  wire logic          start_i,     // fire pulse
  input  wire logic [VW-1:0] vin_level_i, // input supply level
  output logic               active_o,    // pulse running
  output logic               done_o       // one cycle at pulse end
);
  logic [15:0]   acc_reg;   // charge collected so far
  logic          act_reg;
  logic          done_reg;
  logic [VW-1:0] vin_eff;   // zero would never end the pulse
  logic [16:0]   acc_sum;
  logic          reached;

  // higher input charges faster, so the pulse shrinks [R01]
  assign vin_eff = (vin_level_i == '0) ? VW'(1) : vin_level_i;
  assign acc_sum = {1'b0, acc_reg} + 17'(vin_eff);
  assign reached = acc_sum >= {1'b0, CHARGE}; // only the level counts [R01]

  // accumulator runs while the pulse is active
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      acc_reg  <= 16'h0000;
      act_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else if (start_i) begin
      acc_reg  <= 16'h0000;
      act_reg  <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      done_reg <= act_reg && reached;
      if (act_reg && reached) act_reg <= 1'b0;
      else if (act_reg) acc_reg <= acc_sum[15:0];
    end
  end

  assign active_o = act_reg;
  assign done_o   = done_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_shot_ends: assert property (act_reg && reached && !start_i |=> // [R01]
    !act_reg && done_reg) else $error("one-shot did not end");
endmodule // bcf_oneshot
`default_nettype wire

// >>> rtl/bcf_slew.sv
// slew-limited regulation target
`timescale 1ns/10ps
`default_nettype none
`include "bcf_cfg.svh"
module bcf_slew #(
  parameter int DW  = 12,
  parameter int DIV = `BCF_SLEW_DIV
) (
  input  wire logic          clock_i,
  input  wire logic          rst_n_i,
  input  wire logic          load_i,   // follow load value directly
  input  wire logic [DW-1:0] load_value_i,
  input  wire logic [DW-1:0] goal_i,   // programmed target
  output logic [DW-1:0]      value_o,  // present target
  output logic               busy_o    // target still moving
);
  logic [DW-1:0] val_reg;
  logic [7:0]    div_reg;  // step pacing
  logic          tick;

  assign tick = div_reg == 8'(DIV - 1);

  // one lsb per DIV cycles toward the goal, no jump except a load_i reload [R12]
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      val_reg <= '0;
      div_reg <= 8'h00;
    end else if (load_i) begin
      val_reg <= load_value_i;
      div_reg <= 8'h00;
    end else begin
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
      if (tick && val_reg < goal_i) val_reg <= val_reg + DW'(1); // [R12]
      else if (tick && val_reg > goal_i) val_reg <= val_reg - DW'(1);
    end
  end

  assign value_o = val_reg;
  assign busy_o  = !load_i && (val_reg != goal_i);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_slew_step: assert property (!load_i |=> // [R12]
    (val_reg - $past(val_reg) <= DW'(1)) ||
    ($past(val_reg) - val_reg <= DW'(1))) else $error("target jumped");
endmodule // bcf_slew
`default_nettype wire

// >>> rtl/bcf_fault_ctrl.sv
// constant-on-time switching and fault sequencing, top level
// Function
// R01: on-time set only by input supply level
// R02: fire when reference exceeds output plus ripple
// R03: hold high side off 300 ns after on-time
// R04: over limit keeps low side on, blocks cycles
// R05: sixteen limited cycles latch both switches off
// R06: latched fault left only by enable retrigger; in auto mode the code also leaves it after the recovery wait
// R07: below 70 percent for 32 us latches off
// R08: 20 percent over reference clamps low side
// R09: clamp released once output drops below reference
// R10: code maps linearly from 0.6 V, 9.375 mV
// R11: power-up target taken from divider input
// R12: target slews toward new code value
// R13: odd parity mismatch refuses write, keeps code
// R14: protection mode picks auto-recovery or latch-off
// R15: optional protection suspend while code changes
// R16: enable low restores default settings
// R17: clean cycle clears over-current cycle count
// R18: enable low: switches off, faults cleared
`timescale 1ns/10ps
`default_nettype none
`include "bcf_cfg.svh"
module bcf_fault_ctrl #(
  parameter int VW = 8,                      // input level width
  parameter int DW = 12,                     // voltage word width
  parameter int UV_DELAY_CYC = `BCF_UV_DELAY_CYC,
  parameter int RECOVER_CYC  = `BCF_RECOVER_CYC
) (
  input  wire logic          clock_i,
  input  wire logic          rst_n_i,
  input  wire logic          enable_i,                  // converter enable
  input  wire logic [VW-1:0] vin_level_i,               // input supply level
  input  wire logic [DW-1:0] reference_divider_input_i, // start-up target
  input  wire logic [DW-1:0] output_sense_i,            // sensed output
  input  wire logic [DW-1:0] ripple_info_i,             // inductor ac current
  input  wire logic          ls_over_limit_i,           // low-side over limit
  input  wire logic          code_wr_i,                 // code write strobe
  input  wire logic [6:0]    code_data_i,               // new output code
  input  wire logic          code_parity_i,             // odd parity bit
  input  wire logic          cfg_wr_i,                  // settings write
  input  wire logic [2:0]    cfg_data_i,                // settings value
  output logic               hs_on_o,                   // high-side switch
  output logic               ls_on_o,                   // low-side switch
  output logic               code_ack_o,                // write taken
  output logic               code_nack_o,               // write refused
  output logic [7:0]         code_rd_o,                 // {parity, code}
  output logic [2:0]         cfg_rd_o,                  // settings
  output logic               latched_off_o,             // fault shutdown
  output logic               fault_oc_o,                // last cause: current
  output logic               fault_uv_o,                // last cause: undervolt
  output logic [DW-1:0]      regulation_reference_o     // present target
);
  // sequencer and stored settings
  bcf_pkg::bcf_state_t state_reg, state_next;
  logic [6:0]    code_reg;          // output_voltage_code
  logic          code_par_reg;      // parity stored for read-back
  logic          code_valid_reg;    // a code has been written since enable
  logic [2:0]    cfg_reg;           // latch mode, suspend, light load
  logic          ov_clamp_reg;      // over-voltage clamp active
  logic [4:0]    oc_cnt_reg;        // consecutive limited cycles
  logic [12:0]   uv_cnt_reg;        // under-voltage dwell
  logic [10:0]   rec_cnt_reg;       // auto-recovery wait
  logic [7:0]    off_cnt_reg;       // minimum off time left
  logic          hs_reg, ls_reg, ack_reg, nack_reg, lat_reg;
  logic          fault_oc_reg, fault_uv_reg;

  // decode wires
  logic [DW-1:0] goal, target;
  logic          slewing, shot_active, shot_done, shot_start;
  logic          par_ok, code_take, prot_on, demand;
  logic [DW:0]   sense_plus_ripple;
  logic [15:0]   sense_x, target_x;
  logic          ov_detect, ov_release, uv_cond;
  logic          minoff_end, oc_hit, uv_hit, fault_hit, rec_done;
  logic          ocl_block, ls_idle;

  // code to target in 1/16-step units
  function automatic logic [DW-1:0] code_to_target(input logic [6:0] c);
    code_to_target = `BCF_VT_BASE + (DW'(c) << `BCF_VT_SHIFT); // [R10]
  endfunction

  // odd parity is the xnor of the code bits [R13]
  assign par_ok    = code_parity_i == ~(^code_data_i);
  assign code_take = code_wr_i && par_ok && enable_i;
  // before any code write the divider input rules [R11]
  assign goal = code_valid_reg ? code_to_target(code_reg)
                               : reference_divider_input_i;

  bcf_slew #(
    .DW (DW),
    .DIV(`BCF_SLEW_DIV)
  ) u_slew (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .load_i      (!code_valid_reg),            // [R11]
    .load_value_i(reference_divider_input_i),
    .goal_i      (goal),
    .value_o     (target),
    .busy_o      (slewing)
  );

  bcf_oneshot #(
    .VW    (VW),
    .CHARGE(`BCF_ON_CHARGE)
  ) u_shot (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .start_i    (shot_start),
    .vin_level_i(vin_level_i),
    .active_o   (shot_active),
    .done_o     (shot_done)
  );

  // protection may be suspended while the target moves [R15]
  assign prot_on = !(cfg_reg[`BCF_CFG_SUSPEND] && slewing);
  // on-time trigger comparison [R02]
  assign sense_plus_ripple = {1'b0, output_sense_i} + {1'b0, ripple_info_i};
  assign demand = {1'b0, target} > sense_plus_ripple; // [R02]
  // 20 % over target, released once below target [R08] [R09]
  assign sense_x    = 16'(output_sense_i);
  assign target_x   = 16'(target);
  assign ov_detect  = prot_on &&
    (sense_x * `BCF_OV_SENSE_MUL > target_x * `BCF_OV_REF_MUL); // [R08]
  assign ov_release = output_sense_i < target;                  // [R09]
  assign uv_cond    =
    (sense_x * `BCF_UV_SENSE_MUL < target_x * `BCF_UV_REF_MUL); // [R07]
  // cycle accounting and fault detection
  assign minoff_end = (state_reg == bcf_pkg::st_minoff) &&
                      (off_cnt_reg == 8'h00);
  assign oc_hit = minoff_end && ls_over_limit_i && prot_on &&
                  (oc_cnt_reg == 5'(`BCF_OC_LIMIT - 1));        // [R05]
  assign uv_hit = uv_cond && prot_on &&
                  (uv_cnt_reg == 13'(UV_DELAY_CYC - 1));        // [R07]
  assign fault_hit = oc_hit || uv_hit;
  assign rec_done  = rec_cnt_reg == 11'(RECOVER_CYC - 1);
  assign ocl_block = ls_over_limit_i;                           // [R04]
  // detect drives the low side on the same edge that sets the clamp flop [R08]
  assign ls_idle   = ov_clamp_reg || ov_detect || ocl_block ||
                     cfg_reg[`BCF_CFG_LIGHT];

  // next state of the switching sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bcf_pkg::st_off: begin
        if (enable_i) state_next = bcf_pkg::st_idle;
      end
      bcf_pkg::st_idle: begin
        if (fault_hit) state_next = bcf_pkg::st_latch;
        else if (ov_clamp_reg || ov_detect) state_next = bcf_pkg::st_idle;
        else if (demand && ocl_block)  // blocked: count another cycle [R04]
          state_next = bcf_pkg::st_minoff;
        else if (demand && off_cnt_reg == 8'h00) // [R02] [R03]
          state_next = bcf_pkg::st_on;
      end
      bcf_pkg::st_on: begin
        if (fault_hit) state_next = bcf_pkg::st_latch;
        else if (ov_detect) state_next = bcf_pkg::st_minoff; // [R03] [R08]
        else if (shot_done) state_next = bcf_pkg::st_minoff; // [R03]
      end
      bcf_pkg::st_minoff: begin
        if (fault_hit) state_next = bcf_pkg::st_latch; // [R05]
        else if (minoff_end) state_next = bcf_pkg::st_idle; // [R03]
      end
      bcf_pkg::st_latch: begin
        // latch mode waits for enable; auto mode retries [R06] [R14]
        if (!cfg_reg[`BCF_CFG_PROT_LATCH] && rec_done)
          state_next = bcf_pkg::st_idle;
      end
      default: state_next = bcf_pkg::st_off;
    endcase
    if (!enable_i) state_next = bcf_pkg::st_off; // [R18]
  end

  assign shot_start = (state_next == bcf_pkg::st_on) &&
                      (state_reg != bcf_pkg::st_on);

  // sequencer state and switch commands, both from flops
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg <= bcf_pkg::st_off;
      hs_reg    <= 1'b0;
      ls_reg    <= 1'b0;
      lat_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      hs_reg    <= state_next == bcf_pkg::st_on;
      lat_reg   <= state_next == bcf_pkg::st_latch; // [R05] [R07]
      // low side carries the off interval, the limit and the clamp
      ls_reg    <= (state_next == bcf_pkg::st_minoff) ||
                   ((state_next == bcf_pkg::st_idle) && ls_idle); // [R04]
    end
  end

  // minimum off timer, loaded on entry to the off interval and on any
  // high-side drop, so a fault exit or quick retry keeps the floor too
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) off_cnt_reg <= 8'h00;
    else if ((state_next == bcf_pkg::st_minoff &&
              state_reg != bcf_pkg::st_minoff) ||
             (hs_reg && state_next != bcf_pkg::st_on))
      off_cnt_reg <= 8'(`BCF_MIN_OFF_CYC - 1); // [R03]
    else if (off_cnt_reg != 8'h00) off_cnt_reg <= off_cnt_reg - 8'h01;
  end

  // consecutive over-current cycles; a clean cycle clears it
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !enable_i) oc_cnt_reg <= 5'h00; // [R18]
    else if (minoff_end && ls_over_limit_i && prot_on)
      oc_cnt_reg <= oc_cnt_reg + 5'h01; // [R05]
    else if (minoff_end) oc_cnt_reg <= 5'h00; // [R17]
  end

  // under-voltage dwell counter, counts only while running
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !enable_i) uv_cnt_reg <= 13'h0000;
    else if (uv_cond && prot_on && state_reg != bcf_pkg::st_latch &&
             state_reg != bcf_pkg::st_off)
      uv_cnt_reg <= uv_cnt_reg + 13'h0001; // [R07]
    else uv_cnt_reg <= 13'h0000;
  end

  // over-voltage clamp: set on detect, held until below target
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !enable_i) ov_clamp_reg <= 1'b0;
    else if (ov_detect) ov_clamp_reg <= 1'b1; // [R08]
    else if (ov_release) ov_clamp_reg <= 1'b0; // [R09]
  end

  // auto-recovery wait inside the latched state
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || state_reg != bcf_pkg::st_latch) rec_cnt_reg <= 11'h000;
    else if (!rec_done) rec_cnt_reg <= rec_cnt_reg + 11'h001; // [R14]
  end

  // fault cause flags, cleared with the latch by enable low
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !enable_i) begin
      fault_oc_reg <= 1'b0; // [R18]
      fault_uv_reg <= 1'b0;
    end else if (fault_hit) begin
      fault_oc_reg <= oc_hit;
      fault_uv_reg <= uv_hit && !oc_hit;
    end
  end

  // code and settings; enable low restores defaults [R16]
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !enable_i) begin
      code_reg       <= `BCF_CODE_DEFAULT; // [R16]
      code_par_reg   <= ~(^`BCF_CODE_DEFAULT);
      code_valid_reg <= 1'b0;
      cfg_reg        <= `BCF_CFG_DEFAULT; // [R14] [R16]
    end else begin
      if (code_take) begin
        code_reg       <= code_data_i; // [R13]
        code_par_reg   <= code_parity_i;
        code_valid_reg <= 1'b1;
      end
      if (cfg_wr_i) cfg_reg <= cfg_data_i;
    end
  end

  // write answers, one cycle each
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ack_reg  <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      ack_reg  <= code_take;
      nack_reg <= code_wr_i && !code_take; // [R13]
    end
  end

  assign hs_on_o                = hs_reg;
  assign ls_on_o                = ls_reg;
  assign code_ack_o             = ack_reg;
  assign code_nack_o            = nack_reg;
  assign code_rd_o              = {code_par_reg, code_reg};
  assign cfg_rd_o               = cfg_reg;
  assign latched_off_o          = lat_reg;
  assign fault_oc_o             = fault_oc_reg;
  assign fault_uv_o             = fault_uv_reg;
  assign regulation_reference_o = target;

  // helper: cycles since high side last dropped, saturating
  logic [7:0] gap_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) gap_reg <= 8'hff;
    else if (hs_reg) gap_reg <= 8'h00;
    else if (gap_reg != 8'hff) gap_reg <= gap_reg + 8'h01;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_switch_excl:  assert property (!(hs_on_o && ls_on_o))
    else $error("both switches on");
  a_min_off_gap:  assert property ($rose(hs_on_o) |-> // [R03]
    gap_reg >= 8'(`BCF_MIN_OFF_CYC)) else $error("off time too short");
  a_limit_block:  assert property (ls_over_limit_i && !hs_on_o |=> // [R04]
    !hs_on_o) else $error("cycle started over limit");
  a_oc_latch:     assert property (oc_hit && enable_i |=> // [R05]
    latched_off_o && !hs_on_o && !ls_on_o) else $error("no oc latch");
  a_latch_hold:   assert property (latched_off_o && enable_i && // [R06]
    cfg_reg[`BCF_CFG_PROT_LATCH] |=> latched_off_o)
    else $error("latch left without enable");
  a_uv_latch:     assert property (uv_hit && enable_i |=> // [R07]
    latched_off_o && fault_uv_o) else $error("no uv latch");
  a_ov_clamp:     assert property (ov_detect && enable_i && // [R08]
    !fault_hit && !latched_off_o |=> !hs_on_o && ls_on_o)
    else $error("ov clamp missing");
  a_parity_refuse: assert property (code_wr_i && !par_ok |=> // [R13]
    code_nack_o && $stable(code_reg)) else $error("bad parity taken");
  a_code_default: assert property (!enable_i |=> // [R16]
    code_reg == `BCF_CODE_DEFAULT && cfg_reg == `BCF_CFG_DEFAULT)
    else $error("settings not restored");
  a_oc_clear:     assert property (minoff_end && !ls_over_limit_i |=> // [R17]
    oc_cnt_reg == 5'h00) else $error("oc count kept");
  a_disable_off:  assert property (!enable_i |=> // [R18]
    !hs_on_o && !ls_on_o && !latched_off_o) else $error("on while off");

  c_oc_latch:   cover property (oc_hit ##1 latched_off_o);
  c_uv_latch:   cover property (uv_hit ##1 latched_off_o);
  c_ov_clamp:   cover property (ov_clamp_reg ##[1:50] !ov_clamp_reg);
  c_code_taken: cover property (code_ack_o ##[1:200] !slewing);
endmodule // bcf_fault_ctrl
`default_nettype wire

// >>> sim/bcf_stage_model.sv
// power stage and comparator model at the far side of the switching block
`timescale 1ns/10ps
`default_nettype none
module bcf_stage_model (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        hs_on_i,     // high-side command
  input  wire logic        ls_on_i,     // low-side command
  input  wire logic        oc_i,        // bench: current above limit
  input  wire logic        force_i,     // bench: pin the output level
  input  wire logic [11:0] force_lvl_i, // pinned output level
  output logic [11:0]      output_sense_o,
  output logic [11:0]      ripple_o,
  output logic             ls_over_limit_o
);
  logic [1:0] dec_reg; // slow sag prescaler
  // output climbs while the high side conducts and sags slowly otherwise;
  // a pinned level becomes the new state so release has no jump
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      output_sense_o <= 12'h4f0;
      dec_reg        <= 2'h0;
    end else if (force_i) begin
      output_sense_o <= force_lvl_i;
    end else if (hs_on_i) begin
      output_sense_o <= output_sense_o + 12'h001;
    end else begin
      dec_reg <= dec_reg + 2'h1;
      if (dec_reg == 2'h3) begin
        output_sense_o <= output_sense_o - 12'h001;
      end
    end
  end
  // current is sensed on the low-side switch only, so both depend on it
  assign ripple_o        = ls_on_i ? 12'h002 : 12'h000;
  assign ls_over_limit_o = oc_i & ls_on_i;
endmodule // bcf_stage_model
`default_nettype wire

// >>> sim/bcf_fault_ctrl_tb_top.sv
// self-checking bench for the switching and fault sequencing block
`timescale 1ns/10ps
`default_nettype none
module bcf_fault_ctrl_tb_top;
  logic        clock_i, rst_n_i, enable_i, oc, frc;
  logic        code_wr_i, code_parity_i, cfg_wr_i;
  logic [7:0]  vin, code_rd;
  logic [11:0] div_lvl, sense, ripple, flvl, ref_o;
  logic [6:0]  code_data_i;
  logic [2:0]  cfg_data_i, cfg_rd;
  logic        hs, ls, over, ack, nack, lat, f_oc, f_uv, a, n;
  int          err_total, check_count, w1, w2, g, h;

  // short fault delays keep the run brief
  bcf_fault_ctrl #(.UV_DELAY_CYC(200), .RECOVER_CYC(8)) u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .enable_i(enable_i),
    .vin_level_i(vin), .reference_divider_input_i(div_lvl),
    .output_sense_i(sense), .ripple_info_i(ripple),
    .ls_over_limit_i(over), .code_wr_i(code_wr_i),
    .code_data_i(code_data_i), .code_parity_i(code_parity_i),
    .cfg_wr_i(cfg_wr_i), .cfg_data_i(cfg_data_i), .hs_on_o(hs),
    .ls_on_o(ls), .code_ack_o(ack), .code_nack_o(nack),
    .code_rd_o(code_rd), .cfg_rd_o(cfg_rd), .latched_off_o(lat),
    .fault_oc_o(f_oc), .fault_uv_o(f_uv), .regulation_reference_o(ref_o));
  bcf_stage_model u_stage (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .hs_on_i(hs), .ls_on_i(ls),
    .oc_i(oc), .force_i(frc), .force_lvl_i(flvl),
    .output_sense_o(sense), .ripple_o(ripple), .ls_over_limit_o(over));

  // clock generator, 5 ns period
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // settle just after an edge so registered outputs have landed
  task automatic tk(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // cycles spent while the high side equals v, bounded
  task automatic hs_run(input logic v, output int k);
    k = 0;
    #1; // look after the edge, never in its own time step
    while (hs === v && k < 20000) begin
      tk(1);
      k++;
    end
  endtask
  // cycles to shutdown, counting high-side cycles meanwhile
  task automatic lat_wait(output int k, output int c);
    k = 0;
    c = 0;
    #1;
    while (lat !== 1'b1 && k < 3000) begin
      tk(1);
      k++;
      if (hs === 1'b1) c++;
    end
  endtask
  task automatic ref_wait(input logic [11:0] e);
    int k;
    k = 0;
    while (ref_o !== e && k < 16000) begin
      tk(1);
      k++;
    end
  endtask
  // code write; ack and nack are gathered over a short window
  task automatic wr_code(input logic [6:0] c, input logic p);
    @(posedge clock_i);
    code_wr_i     <= 1'b1;
    code_data_i   <= c;
    code_parity_i <= p;
    @(posedge clock_i);
    code_wr_i <= 1'b0;
    a = 1'b0;
    n = 1'b0;
    repeat (3) begin
      #1;
      a = a | ack;
      n = n | nack;
      @(posedge clock_i);
    end
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    {rst_n_i, enable_i, oc, frc, code_wr_i, cfg_wr_i} = 6'h00;
    {code_parity_i, code_data_i, cfg_data_i} = 11'h000;
    vin = 8'h30;
    div_lvl = 12'h500;
    flvl = 12'h000;
    err_total = 0;
    check_count = 0;
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    tk(1);
    chk("cfg_rst", cfg_rd, 3'h5);
    chk("code_rst", code_rd, 8'h80);
    chk("off_rst", {hs, ls, lat}, 3'h0);
    wr_code(7'h11, 1'b1);
    chk("nack_off", {a, n}, 2'h1);
    @(posedge clock_i);
    enable_i <= 1'b1;
    tk(2);
    chk("start_tgt", ref_o, 12'h500);
    // on-time follows only the input level; off time has a floor
    hs_run(1'b0, g);
    hs_run(1'b1, w1);
    @(posedge clock_i);
    vin <= 8'h60;
    hs_run(1'b0, g);
    hs_run(1'b1, w2);
    chk("min_off", (g + 1) >= 60, 1'b1);
    chk("on_time", 16'(w1 - w2), 16'h0020);
    wr_code(7'h11, 1'b0);
    chk("bad_par", {a, n, code_rd}, 10'h180);
    wr_code(7'h11, 1'b1);
    chk("good_par", {a, n, code_rd}, 10'h291);
    chk("slewing", ref_o < 12'h510, 1'b1);
    ref_wait(12'h510);
    chk("code17", ref_o, 12'h510);
    // output above target: no firing; far above: clamp; below: resume
    hs_run(1'b1, g);
    @(posedge clock_i);
    frc  <= 1'b1;
    flvl <= 12'h520;
    tk(80);
    lat_wait(g, h);
    chk("no_demand", h, 16'h0000);
    @(posedge clock_i);
    flvl <= 12'h700;
    tk(4);
    chk("ov_clamp", {hs, ls}, 2'h1);
    @(posedge clock_i);
    flvl <= 12'h500;
    hs_run(1'b0, g);
    chk("ov_release", g < 300, 1'b1);
    @(posedge clock_i);
    frc <= 1'b0;
    // persistent over-current latches after sixteen cycles
    hs_run(1'b1, g);
    @(posedge clock_i);
    oc <= 1'b1;
    lat_wait(w1, h);
    chk("oc_span", w1 >= 900 && w1 <= 1100, 1'b1);
    chk("oc_block", h, 16'h0000);
    chk("oc_latch", {hs, ls, f_oc}, 3'h1);
    tk(100);
    chk("oc_hold", lat, 1'b1);
    @(posedge clock_i);
    enable_i <= 1'b0;
    oc <= 1'b0;
    tk(2);
    chk("en_clear", {lat, f_oc, hs, ls}, 4'h0);
    chk("en_code", code_rd, 8'h80);
    @(posedge clock_i);
    enable_i <= 1'b1;
    tk(2);
    chk("restart", lat, 1'b0);
    wr_code(7'h7f, 1'b0);
    ref_wait(12'hbf0);
    chk("code127", ref_o, 12'hbf0);
    // auto-recovery mode, then a shorted output
    @(posedge clock_i);
    cfg_wr_i   <= 1'b1;
    cfg_data_i <= 3'h4;
    @(posedge clock_i);
    cfg_wr_i <= 1'b0;
    tk(2);
    chk("cfg_wr", cfg_rd, 3'h4);
    @(posedge clock_i);
    frc  <= 1'b1;
    flvl <= 12'h000;
    lat_wait(w1, h);
    chk("uv_span", w1 >= 198 && w1 <= 215, 1'b1);
    chk("uv_latch", {hs, ls, f_uv}, 3'h1);
    @(posedge clock_i);
    flvl <= 12'hbf0;
    w2 = 0;
    while (lat !== 1'b0 && w2 < 100) begin
      tk(1);
      w2++;
    end
    chk("auto_rec", lat, 1'b0);
    // suspend protection while the target slews down 240 steps of 8
    // cycles; undervoltage may only latch about 200 cycles after that
    @(posedge clock_i);
    cfg_wr_i   <= 1'b1;
    cfg_data_i <= 3'h2;
    @(posedge clock_i);
    cfg_wr_i <= 1'b0;
    wr_code(7'h70, 1'b0);
    chk("code112", {a, n}, 2'h2);
    @(posedge clock_i);
    flvl <= 12'h000;
    lat_wait(w1, h);
    chk("suspend", w1 >= 2000 && w1 <= 2200, 1'b1);
    stop_test;
  end

  // watchdog, far beyond the expected run length
  initial begin
    #400000;
    err_total++;
    stop_test;
  end
endmodule // bcf_fault_ctrl_tb_top
`default_nettype wire
